// file: rtl/sdct_core.sv
// conversion timing and control core with apb register access
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RL1) internal clock default, external clock selectable
// (RL2) rate code taken from conversion command
// (RL3) single cycle adds 48 clock startup
// (RL4) single cycle codes map 50 to 12800
// (RL5) continuous codes map 1.9 to 16000; the 20-bit count goes down only to 15.6 at code 0011, lower codes give 0
// (RL6) 16000 sps only with fast mode plus
// (RL7) five conversions settle after any change; the code restarts it only on command or control_two writes
// (RL8) self calibration adds 48 clocks
// (RL9) system calibration alone adds 48 clocks
// (RL10) both calibrations add 80 clocks
// (RL11) calibration runs after raw conversion ends
// (RL12) polarity bit selects unipolar or bipolar
// (RL13) reset state bypasses gain stage, powered down
// (RL14) gain 1 to 128, bypass direct
// (RL15) modulator overrange flagged in status
// (RL16) filter overflow flagged in status
// (RL17) sequencer scans channels with delay
// (RL18) results are 24 bits wide
// (RL19) external clock scales all rates
// (RL20) ready low on result, high after read
// (RL21) sync resets filter and modulator
// (RL22) unavailable continuous code rejected, flagged
module sdct_core (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // master clock ticks and converter events
    input wire logic int_mclk_tick,
    input wire logic ext_mclk_tick,
    input wire logic sync_n,
    input wire logic mod_overrange,
    input wire logic filt_overflow,
    input wire logic [23:0] raw_result,
    // analog and pin controls
    output logic result_ready_n,
    output logic unipolar,
    output logic ext_clock_sel,
    output logic gain_stage_en,
    output logic [2:0] gain_code,
    output logic [2:0] mux_chan,
    output logic filter_reset
);
    // -----------------------------------------------------------------
    // registers and state
    // -----------------------------------------------------------------
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [3:0] rate;
    logic cont_mode;
    logic [5:0] seq_mask;
    logic [15:0] seq_delay;
    logic [23:0] result;
    logic [2:0] chan;
    logic [2:0] settle_cnt;
    logic overrange_flag;
    logic overflow_flag;
    logic invalid_flag;
    logic busy;
    logic [19:0] cnt;
    sdct_pkg::sdct_state_type state;
    sdct_pkg::sdct_state_type next_state;
    logic [19:0] next_cnt;

    // conversion length in master clocks per rate code, chosen so that
    // 8192 khz / count gives the nominal rate; an external clock scales it
    function automatic logic [19:0] conv_len(input logic [3:0] code, input logic cont);
        logic [19:0] sc;
        sc = 20'h00000;
        case (code)
            4'h0: sc = 20'h28000;    // 50 sps
            4'h1: sc = 20'h20000;    // 62.5
            4'h2: sc = 20'h14000;    // 100
            4'h3: sc = 20'h10000;    // 125
            4'h4: sc = 20'h0a000;    // 200
            4'h5: sc = 20'h08000;    // 250
            4'h6: sc = 20'h05000;    // 400
            4'h7: sc = 20'h04000;    // 500
            4'h8: sc = 20'h02800;    // 800
            4'h9: sc = 20'h02000;    // 1000
            4'ha: sc = 20'h01400;    // 1600
            4'hb: sc = 20'h01000;    // 2000
            4'hc: sc = 20'h00a00;    // 3200
            4'hd: sc = 20'h00800;    // 4000
            4'he: sc = 20'h00500;    // 6400
            default: sc = 20'h00280; // 12800
        endcase
        if (cont) begin
            // continuous: 15.6 sps at code 0011 doubling to 16000 at code 1101; codes below 0011 shift out of 20 bits to 0
            conv_len = 20'h00200 << (4'hd - code); // [RL5]
        end else begin
            conv_len = sc; // [RL4]
        end
    endfunction : conv_len

    // -----------------------------------------------------------------
    // decoding
    // -----------------------------------------------------------------
    wire logic mclk_tick;
    wire logic wr_en;
    wire logic rd_en;
    wire logic cmd_wr;
    wire logic cmd_start;
    wire logic [3:0] cmd_rate;
    wire logic cmd_cont;
    wire logic cmd_bad;
    wire logic self_cal;
    wire logic sys_cal;
    wire logic [7:0] cal_len;
    wire logic addr_ok;
    wire logic result_read;
    wire logic settle_kick;
    logic [2:0] next_chan;

    // tick source picks the master clock; rates follow it by construction
    assign mclk_tick = control_one[sdct_pkg::ext_clock_bit] ? ext_mclk_tick
                                                            : int_mclk_tick; // [RL1] [RL19]
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign cmd_wr = wr_en && (paddr == sdct_pkg::command_off);
    assign cmd_start = pwdata[sdct_pkg::cmd_start_bit];
    assign cmd_rate = pwdata[sdct_pkg::cmd_rate_lsb +: 4]; // [RL2]
    assign cmd_cont = pwdata[sdct_pkg::cmd_cont_bit];
    // codes above 1101 do not exist in continuous mode; the top code also
    // needs the host link at fast mode plus
    assign cmd_bad = cmd_cont && ((cmd_rate > sdct_pkg::cont_max_rate) ||
                     ((cmd_rate == sdct_pkg::cont_fast_rate) &&
                      !control_one[sdct_pkg::fast_plus_bit])); // [RL22] [RL6]
    assign self_cal = control_one[sdct_pkg::self_cal_bit];
    assign sys_cal = control_one[sdct_pkg::sys_cal_bit];
    assign cal_len = (self_cal && sys_cal) ? 8'(sdct_pkg::cal_both_mclk) : // [RL10]
                     (self_cal || sys_cal) ? 8'(sdct_pkg::cal_one_mclk) : // [RL8] [RL9]
                     8'h00;
    assign addr_ok = (paddr == sdct_pkg::control_one_off) || (paddr == sdct_pkg::control_two_off)
                  || (paddr == sdct_pkg::command_off) || (paddr == sdct_pkg::status_off)
                  || (paddr == sdct_pkg::result_off) || (paddr == sdct_pkg::seq_off)
                  || (paddr == sdct_pkg::period_off);
    assign result_read = rd_en && (paddr == sdct_pkg::result_off);
    // gain, channel or input change restarts the settle count
    assign settle_kick = cmd_wr || (wr_en && (paddr == sdct_pkg::control_two_off));

    // next enabled channel, wrapping past the top
    always_comb begin
        next_chan = chan;
        for (int k = sdct_pkg::num_chan; k > 0; k--) begin
            if (seq_mask[(chan + k) % sdct_pkg::num_chan]) begin
                next_chan = 3'((chan + k) % sdct_pkg::num_chan);
            end
        end
    end

    // -----------------------------------------------------------------
    // sequencing state machine
    // -----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            sdct_pkg::sdct_idle: begin
                next_cnt = 20'(seq_delay);
                if (busy) begin
                    next_state = sdct_pkg::sdct_delay;
                end
            end
            sdct_pkg::sdct_delay: begin
                // programmable wait before each single conversion and the first continuous one [RL17]
                if (cnt == 20'h00000) begin
                    next_state = cont_mode ? sdct_pkg::sdct_conv : sdct_pkg::sdct_start;
                    next_cnt = cont_mode ? conv_len(rate, 1'b1) - 20'h00002
                                         : 20'(sdct_pkg::startup_mclk - 1); // [RL3]
                end else if (mclk_tick) begin
                    next_cnt = cnt - 20'h00001;
                end
            end
            sdct_pkg::sdct_start: begin
                if (cnt == 20'h00000) begin
                    next_state = sdct_pkg::sdct_conv;
                    next_cnt = conv_len(rate, 1'b0) - 20'h00002;
                end else if (mclk_tick) begin
                    next_cnt = cnt - 20'h00001;
                end
            end
            sdct_pkg::sdct_conv: begin
                if (cnt == 20'h00000) begin
                    // calibration math runs only after the raw result [RL11]
                    next_state = sdct_pkg::sdct_cal;
                    next_cnt = 20'(cal_len);
                end else if (mclk_tick) begin
                    next_cnt = cnt - 20'h00001;
                end
            end
            sdct_pkg::sdct_cal: begin
                if (cnt == 20'h00000) begin
                    // conv loads two short to pay for both exit cycles
                    next_state = cont_mode ? sdct_pkg::sdct_conv : sdct_pkg::sdct_idle;
                    next_cnt = conv_len(rate, 1'b1) - 20'h00002;
                end else if (mclk_tick) begin
                    next_cnt = cnt - 20'h00001;
                end
            end
            default: begin
                next_state = sdct_pkg::sdct_idle;
            end
        endcase
        if (!busy || !sync_n) begin
            next_state = sdct_pkg::sdct_idle; // [RL21]
        end
    end

    // state and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sdct_pkg::sdct_idle;
            cnt <= 20'h00000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // one pulse per finished conversion, calibration included
    wire logic conv_done;
    assign conv_done = (state == sdct_pkg::sdct_cal) && (cnt == 20'h00000) && busy && sync_n;

    // -----------------------------------------------------------------
    // control registers and command handling
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_one <= sdct_pkg::control_one_rst; // [RL12]
            control_two <= sdct_pkg::control_two_rst; // [RL13]
            seq_mask <= 6'h01;
            seq_delay <= 16'h0000;
        end else if (wr_en) begin
            if (paddr == sdct_pkg::control_one_off) begin
                control_one <= pwdata[7:0];
            end
            if (paddr == sdct_pkg::control_two_off) begin
                control_two <= pwdata[7:0];
            end
            if (paddr == sdct_pkg::seq_off) begin
                seq_mask <= pwdata[5:0];
            end
            if (paddr == sdct_pkg::period_off) begin
                seq_delay <= pwdata[15:0];
            end
        end
    end

    // command: a bad continuous code leaves the converter stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate <= 4'h0;
            cont_mode <= 1'b0;
            busy <= 1'b0;
        end else if (cmd_wr && pwdata[sdct_pkg::cmd_stop_bit]) begin
            busy <= 1'b0;
        end else if (cmd_wr && cmd_start) begin
            rate <= cmd_rate; // [RL2]
            cont_mode <= cmd_cont;
            busy <= !cmd_bad; // [RL22]
        end else if (conv_done && !cont_mode && next_chan <= chan) begin
            busy <= 1'b0;
        end
    end

    // channel scan through the enabled mask; skipped channels take no time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan <= 3'h0;
        end else if (cmd_wr && cmd_start) begin
            chan <= pwdata[sdct_pkg::cmd_chan_lsb +: 3];
        end else if (conv_done) begin
            chan <= next_chan; // [RL17]
        end
    end

    // settle: first four continuous results after a change are not ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 3'h0;
        end else if (settle_kick) begin
            settle_cnt <= 3'(sdct_pkg::settle_cycles - 1); // [RL7]
        end else if (conv_done && cont_mode && settle_cnt != 3'h0) begin
            settle_cnt <= settle_cnt - 3'h1;
        end
    end

    // result, ready and sticky flags; set beats a read-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 24'h000000;
            result_ready_n <= 1'b1;
            overrange_flag <= 1'b0;
            overflow_flag <= 1'b0;
            invalid_flag <= 1'b0;
        end else begin
            if (conv_done && (!cont_mode || settle_cnt == 3'h0)) begin
                result <= raw_result; // [RL18]
                result_ready_n <= 1'b0; // [RL20]
            end else if (result_read) begin
                result_ready_n <= 1'b1; // [RL20]
            end
            if (mod_overrange) begin
                overrange_flag <= 1'b1; // [RL15]
            end else if (rd_en && paddr == sdct_pkg::status_off) begin
                overrange_flag <= 1'b0;
            end
            if (filt_overflow) begin
                overflow_flag <= 1'b1; // [RL16]
            end else if (rd_en && paddr == sdct_pkg::status_off) begin
                overflow_flag <= 1'b0;
            end
            if (cmd_wr && cmd_start && cmd_bad) begin
                invalid_flag <= 1'b1; // [RL22]
            end else if (rd_en && paddr == sdct_pkg::status_off) begin
                invalid_flag <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // apb answer and pin outputs
    // -----------------------------------------------------------------
    wire logic [31:0] rd_mux;
    assign rd_mux = (paddr == sdct_pkg::control_one_off) ? {24'h000000, control_one} :
                    (paddr == sdct_pkg::control_two_off) ? {24'h000000, control_two} :
                    (paddr == sdct_pkg::command_off) ? {21'h000000, chan, rate, 2'h0,
                                                        cont_mode, busy} :
                    (paddr == sdct_pkg::status_off) ? {24'h000000, !result_ready_n,
                                                       settle_cnt, invalid_flag,
                                                       overflow_flag, overrange_flag, busy} :
                    (paddr == sdct_pkg::result_off) ? {8'h00, result} :
                    (paddr == sdct_pkg::seq_off) ? {26'h0000000, seq_mask} :
                    (paddr == sdct_pkg::period_off) ? {16'h0000, seq_delay} :
                    32'h00000000;

    // zero wait state: pready rises in the first access cycle, registered from setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // analog controls; registered so every output comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unipolar <= 1'b0;
            ext_clock_sel <= 1'b0;
            gain_stage_en <= 1'b0;
            gain_code <= 3'h0;
            mux_chan <= 3'h0;
            filter_reset <= 1'b1;
        end else begin
            unipolar <= control_one[sdct_pkg::polarity_bit]; // [RL12]
            ext_clock_sel <= control_one[sdct_pkg::ext_clock_bit]; // [RL1]
            gain_stage_en <= control_two[sdct_pkg::gain_en_bit]; // [RL13] [RL14]
            gain_code <= control_two[sdct_pkg::gain_lsb +: 3]; // [RL14]
            mux_chan <= chan;
            filter_reset <= !sync_n || state == sdct_pkg::sdct_idle; // [RL21]
        end
    end
endmodule : sdct_core
`default_nettype wire

// file: rtl/sdct_pkg.sv
// shared constants for the sigma-delta conversion timing core
package sdct_pkg;
    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] control_one_off = 8'h00;
    localparam logic [7:0] control_two_off = 8'h04;
    localparam logic [7:0] command_off = 8'h08;
    localparam logic [7:0] status_off = 8'h0c;
    localparam logic [7:0] result_off = 8'h10;
    localparam logic [7:0] seq_off = 8'h14;
    localparam logic [7:0] period_off = 8'h18;
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int polarity_bit = 0;     // control_one: 1 = unipolar
    localparam int ext_clock_bit = 1;    // control_one: 1 = external clock
    localparam int self_cal_bit = 2;     // control_one
    localparam int sys_cal_bit = 3;      // control_one
    localparam int fast_plus_bit = 4;    // control_one: link in fast mode plus
    localparam int gain_en_bit = 0;      // control_two: gain stage powered
    localparam int gain_lsb = 1;         // control_two: log2 gain, 3 bits
    localparam int cmd_start_bit = 0;    // command
    localparam int cmd_cont_bit = 1;     // command: continuous mode
    localparam int cmd_stop_bit = 2;     // command
    localparam int cmd_rate_lsb = 4;     // command: rate code, 4 bits
    localparam int cmd_chan_lsb = 8;     // command: channel, 3 bits
    // -----------------------------------------------------------------
    // reset values and timing
    // -----------------------------------------------------------------
    localparam logic [7:0] control_one_rst = 8'h00;
    localparam logic [7:0] control_two_rst = 8'h00;   // gain stage off, bypass
    localparam int mclk_khz = 8192;
    localparam int startup_mclk = 48;
    localparam int cal_one_mclk = 48;
    localparam int cal_both_mclk = 80;
    localparam int settle_cycles = 5;
    localparam int num_chan = 6;
    localparam int result_width = 24;
    localparam logic [3:0] cont_max_rate = 4'hd;
    localparam logic [3:0] cont_fast_rate = 4'hd;
    // -----------------------------------------------------------------
    // state encodings
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        sdct_idle = 5'b00001,
        sdct_delay = 5'b00010,
        sdct_start = 5'b00100,
        sdct_conv = 5'b01000,
        sdct_cal = 5'b10000
    } sdct_state_type;
endpackage : sdct_pkg

// file: verif/sdct_core_chk.sv
// port-level assertions for the conversion timing core
`timescale 1ns/1ps
`default_nettype none
module sdct_core_chk (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter side
    input wire logic sync_n,
    input wire logic result_ready_n,
    input wire logic gain_stage_en,
    input wire logic [2:0] gain_code,
    input wire logic filter_reset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // bus steps
    // ------------------------------------------------------------
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    // the slave answers in the first access cycle, no wait states
    zero_wait_a: assert property (setup_s |=> access_s)
        else $error("ready missing in access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    read_zero_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    bad_addr_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not refused");
    // ------------------------------------------------------------
    // converter behaviour
    // ------------------------------------------------------------
    sync_hold_a: assert property (!sync_n |=> filter_reset)
        else $error("sync low but filter not in reset");
    read_release_a: assert property (access_s ##0 (!pwrite && paddr == 8'h10) |=> result_ready_n)
        else $error("ready not released by result read");
    gain_copy_a: assert property (access_s ##0 (pwrite && paddr == 8'h04) |=> ##1 gain_stage_en == $past(pwdata[0], 2) && gain_code == $past(pwdata[3:1], 2))
        else $error("gain pins differ from written value");
    reset_state_a: assert property ($rose(presetn) |-> result_ready_n && filter_reset && !gain_stage_en)
        else $error("wrong pin state after reset");
endmodule : sdct_core_chk
`default_nettype wire

// file: verif/sdct_front.sv
// converter front end model: master clock ticks and modulator sample
`timescale 1ns/1ps
`default_nettype none
module sdct_front #(
    parameter logic [23:0] sample_value = 24'h5a3c96
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // to the core
    output logic int_mclk_tick,
    output logic ext_mclk_tick,
    output logic [23:0] raw_result
);
    // oscillator ticks every cycle, so tick counts equal cycle counts
    assign int_mclk_tick = presetn;
    // external clock at half rate: every duration must double
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_mclk_tick <= 1'b0;
        end else begin
            ext_mclk_tick <= !ext_mclk_tick;
        end
    end
    // a distinct value in each byte so a dropped byte shows
    assign raw_result = sample_value;
endmodule : sdct_front
`default_nettype wire

// file: verif/sdct_core_bench.sv
// self-checking bench for the conversion timing core
`timescale 1ns/1ps
`default_nettype none
module sdct_core_bench;
    // ------------------------------------------------------------
    // stimulus, wiring and counters
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sync_n = 1'b1;
    logic mod_overrange = 1'b0;
    logic filt_overflow = 1'b0;
    logic [31:0] prdata, q;
    logic pready, pslverr, int_tick, ext_tick, result_ready_n, unipolar, ext_sel, e;
    logic gain_stage_en, filter_reset;
    logic [2:0] gain_code;
    logic [23:0] raw;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int t;
    // first entry uses the sequencer delay; the rest clear it again
    int ctl [7] = '{0, 0, 0, 4, 8, 12, 2};
    int rate [7] = '{15, 15, 14, 15, 15, 15, 15};
    int dly [7] = '{100, 0, 0, 0, 0, 0, 0};
    int tks [7] = '{788, 688, 1328, 736, 736, 768, 1376};
    always #20 pclk = ~pclk;
    sdct_front fe (.pclk, .presetn, .int_mclk_tick(int_tick), .ext_mclk_tick(ext_tick),
        .raw_result(raw));
    sdct_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .int_mclk_tick(int_tick), .ext_mclk_tick(ext_tick), .sync_n,
        .mod_overrange, .filt_overflow, .raw_result(raw), .result_ready_n, .unipolar,
        .ext_clock_sel(ext_sel), .gain_stage_en, .gain_code, .mux_chan(), .filter_reset);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // durations allow a few cycles of pipeline, far less than one 48-tick step
    task automatic chk_near(input string n, input int x, input int g);
        tests_run++;
        if (g < x - 8 || g > x + 8) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", n, x, g);
        end
    endtask : chk_near
    // one apb transfer; the answer is taken at the edge that samples pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bad_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_rdy(output int c);
        c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while (result_ready_n !== 1'b0 && c < 8000);
    endtask : wait_rdy
    // cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("reset pins", 32'h6, {29'h0, result_ready_n, filter_reset, gain_stage_en});
        apb(1'b0, sdct_pkg::control_two_off, 32'h0);
        chk("control_two reset", 32'h0, q);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped access", 32'h1, {q[30:0], e});
        apb(1'b1, sdct_pkg::control_one_off, 32'h3);
        apb(1'b1, sdct_pkg::control_two_off, 32'hf);
        repeat (2) @(negedge pclk);
        chk("pin copies", 32'h3f, {26'h0, unipolar, ext_sel, gain_stage_en, gain_code});
        apb(1'b1, sdct_pkg::control_two_off, 32'h0);
        apb(1'b1, sdct_pkg::seq_off, 32'h1);
        $display("test controls done");
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, sdct_pkg::control_one_off, 32'(ctl[i]));
            apb(1'b1, sdct_pkg::period_off, 32'(dly[i]));
            apb(1'b1, sdct_pkg::command_off, 32'(rate[i] * 16 + 1));
            wait_rdy(t);
            chk_near("single ticks", tks[i], t);
            apb(1'b0, sdct_pkg::result_off, 32'h0);
            chk("result word", 32'h005a3c96, q);
            @(negedge pclk);
            chk("ready after read", 32'h1, {31'h0, result_ready_n});
        end
        $display("test single timing done");
        apb(1'b1, sdct_pkg::command_off, 32'he3);
        apb(1'b0, sdct_pkg::status_off, 32'h0);
        chk("code e refused", 32'h8, q & 32'h9);
        apb(1'b1, sdct_pkg::command_off, 32'hd3);
        apb(1'b0, sdct_pkg::status_off, 32'h0);
        chk("code d slow link", 32'h8, q & 32'h9);
        apb(1'b1, sdct_pkg::control_one_off, 32'h10);
        apb(1'b1, sdct_pkg::command_off, 32'hd3);
        wait_rdy(t);
        chk_near("settled first", 2560, t);
        apb(1'b0, sdct_pkg::result_off, 32'h0);
        wait_rdy(t);
        chk_near("next result", 509, t);
        apb(1'b1, sdct_pkg::command_off, 32'h4);
        $display("test continuous done");
        mod_overrange <= 1'b1;
        @(posedge pclk);
        mod_overrange <= 1'b0;
        apb(1'b0, sdct_pkg::status_off, 32'h0);
        chk("overrange flag", 32'h2, q & 32'h6);
        filt_overflow <= 1'b1;
        @(posedge pclk);
        filt_overflow <= 1'b0;
        apb(1'b0, sdct_pkg::status_off, 32'h0);
        chk("overflow flag", 32'h4, q & 32'h6);
        apb(1'b0, sdct_pkg::status_off, 32'h0);
        chk("flags cleared", 32'h0, q & 32'he);
        $display("test flags done");
        sync_n <= 1'b0;
        apb(1'b1, sdct_pkg::command_off, 32'hf1);
        apb(1'b0, sdct_pkg::status_off, 32'h0);
        chk("sync armed", 32'h1, q & 32'h1);
        @(negedge pclk);
        chk("filter reset", 32'h1, {31'h0, filter_reset});
        sync_n <= 1'b1;
        $display("test sync done");
        finish_test();
    end
endmodule : sdct_core_bench
bind sdct_core sdct_core_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sync_n, .result_ready_n, .gain_stage_en,
    .gain_code, .filter_reset);
`default_nettype wire
